// File: common/flash_reset_pkg.sv
// shared constants and types for the flash reset/power-down host controller
package flash_reset_pkg;

    // ==================================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESET_PULSE_MIN_NS = 100;
    localparam int IDLE_RESET_NS = 100;
    localparam int ABORT_ERASE_US = 22;
    localparam int ABORT_PROGRAM_US = 12;
    localparam int WRITE_RECOVERY_NS = 150;
    localparam int READ_RECOVERY_NS = 150;
    localparam int NS_PER_US = 1000;

    localparam int CNT_W = 10;

    localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_RESET_CYC = (IDLE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ABORT_ERASE_CYC =
        (ABORT_ERASE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ABORT_PROGRAM_CYC =
        (ABORT_PROGRAM_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_RECOVERY_CYC = (READ_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;

    // ==================================================
    // operation kinds the flash may be running
    typedef enum logic [1:0] {
        OP_NONE,
        OP_PROGRAM,
        OP_ERASE
    } opKind_t;

    typedef enum logic [1:0] {
        ST_RESET_LOW,
        ST_RECOVER,
        ST_ACTIVE
    } ctrlState_t;

    // ==================================================
    // user side requests
    typedef struct packed {
        logic resetReq;
        logic powerDownReq;
        opKind_t opKind;
        logic opDone;
        logic readArrayIssued;
    } hostReq_t;

    // user bus strobes, active low
    typedef struct packed {
        logic ceN;
        logic weN;
        logic oeN;
    } busStrobe_t;

    // pins toward the flash
    typedef struct packed {
        logic resetPowerdownN;
        logic ceN;
        logic weN;
        logic oeN;
    } flashPins_t;

    typedef struct packed {
        logic readReady;
        logic writeReady;
        logic readArrayDue;
        logic inReset;
    } hostStatus_t;

endpackage

// File: hdl/flash_reset_host.sv
// host controller for the flash reset/power-down pin and strobe gating
`timescale 1ns/1ps

module flash_reset_host #(
    parameter int RESET_PULSE_CYC = flash_reset_pkg::RESET_PULSE_MIN_CYC,
    parameter int IDLE_CYC = flash_reset_pkg::IDLE_RESET_CYC,
    parameter int ERASE_ABORT_CYC = flash_reset_pkg::ABORT_ERASE_CYC,
    parameter int PROGRAM_ABORT_CYC = flash_reset_pkg::ABORT_PROGRAM_CYC,
    parameter int READ_REC_CYC = flash_reset_pkg::READ_RECOVERY_CYC,
    parameter int WRITE_REC_CYC = flash_reset_pkg::WRITE_RECOVERY_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire flash_reset_pkg::hostReq_t hostReq,
    input wire flash_reset_pkg::busStrobe_t busStrobe,
    output flash_reset_pkg::flashPins_t flashPins,
    output flash_reset_pkg::hostStatus_t hostStatus
);

    // ==================================================
    // state
    typedef struct packed {
        flash_reset_pkg::ctrlState_t state;
        logic [flash_reset_pkg::CNT_W-1:0] cnt;
        flash_reset_pkg::flashPins_t pins;
        flash_reset_pkg::hostStatus_t status;
    } ctrl_t;

    // counts cut to the counter width; the package keeps them in range
    localparam logic [flash_reset_pkg::CNT_W-1:0] PULSE_CNT =
        RESET_PULSE_CYC[flash_reset_pkg::CNT_W-1:0];
    localparam logic [flash_reset_pkg::CNT_W-1:0] IDLE_CNT =
        IDLE_CYC[flash_reset_pkg::CNT_W-1:0];
    localparam logic [flash_reset_pkg::CNT_W-1:0] ERASE_CNT =
        ERASE_ABORT_CYC[flash_reset_pkg::CNT_W-1:0];
    localparam logic [flash_reset_pkg::CNT_W-1:0] PROG_CNT =
        PROGRAM_ABORT_CYC[flash_reset_pkg::CNT_W-1:0];
    localparam logic [flash_reset_pkg::CNT_W-1:0] READ_CNT =
        READ_REC_CYC[flash_reset_pkg::CNT_W-1:0];
    localparam logic [flash_reset_pkg::CNT_W-1:0] WRITE_CNT =
        WRITE_REC_CYC[flash_reset_pkg::CNT_W-1:0];
    // recovery runs to the longer of the two delays
    localparam logic [flash_reset_pkg::CNT_W-1:0] REC_CNT =
        (READ_REC_CYC > WRITE_REC_CYC) ? READ_CNT : WRITE_CNT;

    // strobes parked high while the reset pin is low
    localparam flash_reset_pkg::flashPins_t PARKED_PINS = '{
        resetPowerdownN: 1'b0,
        ceN: 1'b1,
        weN: 1'b1,
        oeN: 1'b1
    };

    // single state register and its next value
    ctrl_t ctrl_r;
    ctrl_t ctrl_nxt;

    // ==================================================
    // low time needed for the operation in flight
    // worst case of the kind wins; a partial abort still gets the full time
    function automatic logic [flash_reset_pkg::CNT_W-1:0] lowTime(
        input flash_reset_pkg::opKind_t kind
    );
        logic [flash_reset_pkg::CNT_W-1:0] t;
        t = (PULSE_CNT > IDLE_CNT) ? PULSE_CNT : IDLE_CNT;
        unique case (kind)
            flash_reset_pkg::OP_ERASE: begin
                if (ERASE_CNT > t) begin
                    t = ERASE_CNT;
                end
            end
            flash_reset_pkg::OP_PROGRAM: begin
                if (PROG_CNT > t) begin
                    t = PROG_CNT;
                end
            end
            flash_reset_pkg::OP_NONE: begin
            end
            default: begin
                // unused kind code treated as erase, the longest abort
                if (ERASE_CNT > t) begin
                    t = ERASE_CNT;
                end
            end
        endcase
        return t;
    endfunction

    // ==================================================
    // next state
    always_comb begin
        logic [flash_reset_pkg::CNT_W-1:0] elapsed;
        ctrl_nxt = ctrl_r;
        elapsed = REC_CNT - ctrl_r.cnt;
        unique case (ctrl_r.state)
            flash_reset_pkg::ST_RESET_LOW: begin
                // strobes parked high while in deep power-down
                ctrl_nxt.pins = PARKED_PINS;
                ctrl_nxt.status.readReady = 1'b0;
                ctrl_nxt.status.writeReady = 1'b0;
                ctrl_nxt.status.inReset = 1'b1;
                if (ctrl_r.cnt != flash_reset_pkg::CNT_ZERO) begin
                    ctrl_nxt.cnt = ctrl_r.cnt - flash_reset_pkg::CNT_ONE;
                end else if (!hostReq.powerDownReq) begin
                    // pin released only once no power-down is held
                    // recovery starts after the full shutdown interval
                    ctrl_nxt.state = flash_reset_pkg::ST_RECOVER;
                    ctrl_nxt.cnt = REC_CNT;
                    ctrl_nxt.pins.resetPowerdownN = 1'b1;
                    ctrl_nxt.status.inReset = 1'b0;
                end
            end
            flash_reset_pkg::ST_RECOVER: begin
                // reads and writes open separately as each delay runs out
                ctrl_nxt.status.inReset = 1'b0;
                ctrl_nxt.cnt = ctrl_r.cnt - flash_reset_pkg::CNT_ONE;
                if (elapsed + flash_reset_pkg::CNT_ONE >= READ_CNT) begin
                    ctrl_nxt.status.readReady = 1'b1;
                end
                if (elapsed + flash_reset_pkg::CNT_ONE >= WRITE_CNT) begin
                    ctrl_nxt.status.writeReady = 1'b1;
                end
                // last recovery cycle: both directions open
                if (ctrl_r.cnt == flash_reset_pkg::CNT_ONE) begin
                    ctrl_nxt.state = flash_reset_pkg::ST_ACTIVE;
                    ctrl_nxt.status.readReady = 1'b1;
                    ctrl_nxt.status.writeReady = 1'b1;
                end
            end
            flash_reset_pkg::ST_ACTIVE: begin
                // strobes follow the user one cycle late
                ctrl_nxt.status.readReady = 1'b1;
                ctrl_nxt.status.writeReady = 1'b1;
                ctrl_nxt.status.inReset = 1'b0;
            end
            default: begin
                // illegal state code: fall back to a full erase-length reset
                ctrl_nxt.state = flash_reset_pkg::ST_RESET_LOW;
                ctrl_nxt.cnt = lowTime(flash_reset_pkg::OP_ERASE);
            end
        endcase

        // ==================================================
        // strobe gating toward the flash
        if (ctrl_r.state != flash_reset_pkg::ST_RESET_LOW) begin
            ctrl_nxt.pins.ceN = busStrobe.ceN;
            // write needs both strobes low; inhibit until write recovery done
            ctrl_nxt.pins.weN = busStrobe.weN | busStrobe.ceN
                | ~ctrl_nxt.status.writeReady;
            ctrl_nxt.pins.oeN = busStrobe.oeN | ~busStrobe.weN
                | ~ctrl_nxt.status.readReady;
        end

        // ==================================================
        // a reset or power-down request starts the low phase
        // already low: a new request neither restarts nor shortens it
        if (hostReq.resetReq || hostReq.powerDownReq) begin
            if (ctrl_r.state != flash_reset_pkg::ST_RESET_LOW) begin
                ctrl_nxt.state = flash_reset_pkg::ST_RESET_LOW;
                ctrl_nxt.cnt = lowTime(hostReq.opKind) - flash_reset_pkg::CNT_ONE;
                ctrl_nxt.pins = PARKED_PINS;
                ctrl_nxt.status.readReady = 1'b0;
                ctrl_nxt.status.writeReady = 1'b0;
                ctrl_nxt.status.inReset = 1'b1;
            end
        end

        // ==================================================
        // read-array command owed after program/erase; set wins over readArrayIssued, but entering reset low clears it
        if (ctrl_nxt.state == flash_reset_pkg::ST_RESET_LOW) begin
            ctrl_nxt.status.readArrayDue = 1'b0;
        end else if (hostReq.opDone) begin
            ctrl_nxt.status.readArrayDue = 1'b1;
        end else if (hostReq.readArrayIssued) begin
            ctrl_nxt.status.readArrayDue = 1'b0;
        end
    end

    // ==================================================
    // registers; reset holds the flash in deep power-down
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r.state <= flash_reset_pkg::ST_RESET_LOW;
            ctrl_r.cnt <= ERASE_CNT;
            ctrl_r.pins <= PARKED_PINS;
            ctrl_r.status <= '{readReady: 1'b0, writeReady: 1'b0, readArrayDue: 1'b0,
                inReset: 1'b1};
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ==================================================
    // outputs straight from the state register
    assign flashPins = ctrl_r.pins;
    assign hostStatus = ctrl_r.status;

endmodule // flash_reset_host

// File: bench/flash_reset_host_sva.sv
// checker for the flash reset host ports
`timescale 1ns/1ps
module flash_reset_host_sva #(
    parameter int ERASE_ABORT_CYC = flash_reset_pkg::ABORT_ERASE_CYC,
    parameter int PROGRAM_ABORT_CYC = flash_reset_pkg::ABORT_PROGRAM_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire flash_reset_pkg::hostReq_t hostReq,
    input wire flash_reset_pkg::busStrobe_t busStrobe,
    input wire flash_reset_pkg::flashPins_t flashPins,
    input wire flash_reset_pkg::hostStatus_t hostStatus
);
    // ==========
    // pulse length helper
    logic pin;
    int lowCnt_r;
    logic tookReq_r;
    logic [1:0] kind_r;
    assign pin = flashPins.resetPowerdownN;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lowCnt_r <= 0;
            tookReq_r <= 1'b0;
            kind_r <= 2'h0;
        end else begin
            lowCnt_r <= pin ? 0 : lowCnt_r + 1;
            if (pin && hostReq.resetReq) begin
                tookReq_r <= 1'b1;
                kind_r <= hostReq.opKind;
            end else if (pin) begin
                tookReq_r <= 1'b0;
            end
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    pin_quiet_a: assert property (!pin |-> flashPins[2:0] == 3'h7)
        else $error("strobe active in reset");
    write_gate_a: assert property (!flashPins.weN |-> !flashPins.ceN)
        else $error("write without select");
    reset_take_a: assert property (hostReq.resetReq && pin |=> !pin && hostStatus.inReset)
        else $error("reset not taken");
    min_pulse_a: assert property ($fell(pin) |-> !pin [*3])
        else $error("reset pulse short");
    erase_len_a: assert property ($rose(pin) && tookReq_r && kind_r[1] |->
        lowCnt_r == ERASE_ABORT_CYC) else $error("erase abort length");
    prog_len_a: assert property ($rose(pin) && tookReq_r && kind_r == 2'h1 |->
        lowCnt_r == PROGRAM_ABORT_CYC) else $error("program abort length");
    recover_wait_a: assert property ($rose(pin) |->
        (!hostStatus.readReady && !hostStatus.writeReady) [*4] ##1
        (hostStatus.readReady && hostStatus.writeReady)) else $error("recovery length");
    due_set_a: assert property (hostReq.opDone && pin && !hostReq.resetReq &&
        !hostReq.powerDownReq |=> hostStatus.readArrayDue) else $error("read-array not owed");
    due_clear_a: assert property (hostReq.readArrayIssued && !hostReq.opDone && pin |=>
        !hostStatus.readArrayDue) else $error("read-array still owed");
    reset_flag_a: assert property (hostStatus.inReset == !pin)
        else $error("reset flag off pin");
endmodule // flash_reset_host_sva
bind flash_reset_host flash_reset_host_sva #(.ERASE_ABORT_CYC(ERASE_ABORT_CYC),
    .PROGRAM_ABORT_CYC(PROGRAM_ABORT_CYC)) flash_reset_host_sva_inst (.mclk(mclk),
    .sys_rst(sys_rst), .hostReq(hostReq), .busStrobe(busStrobe),
    .flashPins(flashPins), .hostStatus(hostStatus));

// File: bench/flash_model.sv
// behavioural flash: power state, status and write count
`timescale 1ns/1ps
module flash_model #(
    parameter int PROGRAM_MAX_NS = 200000
) (
    input wire logic resetPowerdownN,
    input wire logic ceN,
    input wire logic weN,
    output logic deepDown,
    output logic standby,
    output logic [7:0] status,
    output int writes
);
    // ==========
    // power states
    assign deepDown = !resetPowerdownN;
    assign standby = resetPowerdownN && ceN;
    initial status = 8'h80;
    initial writes = 0;
    always @(negedge resetPowerdownN) status = 8'h80;
    always @(posedge (ceN | weN)) begin
        if (resetPowerdownN) begin
            writes = writes + 1;
            status = 8'h00;
            status[7] <= #(PROGRAM_MAX_NS) 1'b1;
        end
    end
endmodule // flash_model

// File: bench/flash_reset_host_bench.sv
// self-checking bench for the flash reset host
`timescale 1ns/1ps
module flash_reset_host_bench;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    flash_reset_pkg::hostReq_t hostReq = '0;
    flash_reset_pkg::busStrobe_t busStrobe = 3'h7;
    flash_reset_pkg::flashPins_t flashPins;
    flash_reset_pkg::hostStatus_t hostStatus;
    logic deepDown;
    logic standby;
    int writes;
    logic [7:0] status;
    logic timedOut = 1'b0;
    int mismatches = 0;
    int nChecks = 0;
    always #20 mclk = ~mclk;
    flash_reset_host #(.ERASE_ABORT_CYC(8), .PROGRAM_ABORT_CYC(5)) flash_reset_host_inst (
        .mclk(mclk), .sys_rst(sys_rst), .hostReq(hostReq), .busStrobe(busStrobe),
        .flashPins(flashPins), .hostStatus(hostStatus));
    flash_model flash_model_inst (.resetPowerdownN(flashPins.resetPowerdownN),
        .ceN(flashPins.ceN), .weN(flashPins.weN), .deepDown(deepDown),
        .standby(standby), .status(status), .writes(writes));
    // ==========
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        nChecks++;
        if (seen !== want) begin
            mismatches++;
            $display("FAIL %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic timeOut();
        mismatches++;
        timedOut = 1'b1;
        $display("FAIL %0t: wait bound used up", $time);
    endtask
    task automatic waitReady(output int n);
        n = 0;
        while (hostStatus.readReady !== 1'b1 && n < 900) begin
            n++;
            @(negedge mclk);
        end
        if (n >= 900) timeOut();
    endtask
    task automatic finalReport();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic strobeRun();
        int w;
        w = writes;
        busStrobe = 3'h1;
        @(negedge mclk);
        check(flashPins, 4'h9);
        busStrobe = 3'h5;
        @(negedge mclk);
        check(flashPins, 4'hF);
        busStrobe = 3'h2;
        @(negedge mclk);
        check(flashPins, 4'hA);
        busStrobe = 3'h0;
        @(negedge mclk);
        check(flashPins, 4'h9);
        busStrobe = 3'h7;
        @(negedge mclk);
        check(16'(writes - w), 16'h2);
        check(status, 8'h00);
        check(standby, 1'b1);
    endtask
    task automatic powerRun();
        int n;
        hostReq.opKind = flash_reset_pkg::OP_NONE;
        hostReq.powerDownReq = 1'b1;
        repeat (6) begin
            @(negedge mclk);
            check(flashPins.resetPowerdownN, 1'b0);
        end
        check(hostStatus.inReset, 1'b1);
        hostReq.powerDownReq = 1'b0;
        @(negedge mclk);
        check(flashPins.resetPowerdownN, 1'b1);
        waitReady(n);
        check(16'(n), 16'(flash_reset_pkg::READ_RECOVERY_CYC));
        hostReq.opDone = 1'b1;
        hostReq.readArrayIssued = 1'b1;
        @(negedge mclk);
        hostReq.opDone = 1'b0;
        check(hostStatus.readArrayDue, 1'b1);
        @(negedge mclk);
        hostReq.readArrayIssued = 1'b0;
        check(hostStatus.readArrayDue, 1'b0);
    endtask
    task automatic resetRun(input flash_reset_pkg::opKind_t kind, input int want);
        int n;
        int w;
        n = 0;
        hostReq.opDone = 1'b1;
        @(negedge mclk);
        hostReq.opDone = 1'b0;
        check(hostStatus.readArrayDue, 1'b1);
        hostReq.resetReq = 1'b1;
        hostReq.opKind = kind;
        @(negedge mclk);
        busStrobe = 3'h0;
        w = writes;
        while (flashPins.resetPowerdownN !== 1'b1 && n < 99) begin
            if (n == 1) hostReq.resetReq = 1'b0;
            check(flashPins[2:0], 3'h7);
            n++;
            @(negedge mclk);
        end
        if (n >= 99) timeOut();
        busStrobe = 3'h7;
        check(16'(n), 16'(want));
        check(hostStatus.inReset, 1'b0);
        check(16'(writes - w), 16'h0);
        check(status, 8'h80);
        check(hostStatus.readArrayDue, 1'b0);
        waitReady(n);
        check(16'(n), 16'(flash_reset_pkg::READ_RECOVERY_CYC));
        check(hostStatus.writeReady, 1'b1);
    endtask
    initial begin
        int n;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        waitReady(n);
        check(hostStatus.inReset, 1'b0);
        if (!timedOut) strobeRun();
        if (!timedOut) resetRun(flash_reset_pkg::OP_NONE, 3);
        if (!timedOut) resetRun(flash_reset_pkg::OP_PROGRAM, 5);
        if (!timedOut) resetRun(flash_reset_pkg::OP_ERASE, 8);
        if (!timedOut) resetRun(flash_reset_pkg::opKind_t'(2'h3), 8);
        if (!timedOut) powerRun();
        check(deepDown, 1'b0);
        finalReport();
    end
endmodule // flash_reset_host_bench
